// ---- verilog/host_port_device.sv ----
`timescale 1ns/10ps
module host_port_device #(
  parameter int DM_DEPTH = 256, // data memory words
  parameter int PM_DEPTH = 256 // program memory words
) (
  input wire logic ref_clk_i, // processor clock
  input wire logic rst_i, // async reset, high
  host_port_if.device port, // host memory port pins
  input wire logic core_ovl_we_i, // core writes overlay
  input wire logic [15:0] core_ovl_data_i, // core overlay value
  output logic [15:0] overlay_o, // overlay register
  output logic host_mode_o // pins in host port mode
);
  // ---------------------------------------------------------------
  // parameters check
  // ---------------------------------------------------------------
  localparam int DAW = $clog2(DM_DEPTH);
  localparam int PAW = $clog2(PM_DEPTH);
  if (DM_DEPTH < 2 || PM_DEPTH < 2 || DAW > 15 || PAW > 15)
  begin : g_bad
    $error("memory depth out of range");
  end
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} state_t;
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [host_port_pkg::CTL_W-1:0] ctl_s1, ctl_s2; // control sync
  logic [15:0] ad_s1, ad_s2; // bus sync
  logic mode_taken; // strap already captured
  logic host_mode; // captured strap
  state_t state; // access sequencer
  logic busy; // acknowledge held high
  logic [2:0] cnt; // cycles since access seen
  logic [2:0] tgt; // busy length of this access
  logic ended; // access end already seen
  logic [15:0] addr; // latched address
  logic pm_half; // second half of program word
  logic [15:0] pm_hi; // first half of program write
  logic [15:0] wdata; // last sampled write word
  logic [15:0] out_word; // word fetched for reads
  logic rd_oe; // device drives the bus
  logic [15:0] read_word; // word at current address
  logic [15:0] dm [DM_DEPTH]; // data memory
  logic [23:0] pm [PM_DEPTH]; // program memory
  logic sel, lat, rd, wr; // synced active levels
  logic wr_act, rd_act, lat_act; // qualified activities
  logic acc_end; // one cycle at seen end
  logic sro; // fast reads enabled
  logic is_pm, is_ovl; // address decode
  logic raw_acc; // raw pin access start
  // ---------------------------------------------------------------
  // pin synchronisers, plain data flops
  // ---------------------------------------------------------------
  // pins are asynchronous; only the second stage is read
  always_ff @(posedge ref_clk_i)
  begin
    ctl_s1 <= {port.mode_c, port.write_strobe_n, port.read_strobe_n,
      port.address_latch, port.select_n};
    ctl_s2 <= ctl_s1;
    ad_s1 <= port.ad_bus;
    ad_s2 <= ad_s1;
  end
  // ---------------------------------------------------------------
  // mode strap capture
  // ---------------------------------------------------------------
  // caught by a clocked process after release, never by the reset
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_taken <= 1'b0;
      host_mode <= 1'b0;
    end
    else if (!mode_taken)
    begin
      mode_taken <= 1'b1; // RQ12
      host_mode <= ctl_s2[host_port_pkg::CTL_MODE]; // RQ12
    end
  end
  // ---------------------------------------------------------------
  // decode of synced pins
  // ---------------------------------------------------------------
  assign sel = ~ctl_s2[host_port_pkg::CTL_SEL];
  assign lat = ctl_s2[host_port_pkg::CTL_LAT];
  assign rd = ~ctl_s2[host_port_pkg::CTL_RD];
  assign wr = ~ctl_s2[host_port_pkg::CTL_WR];
  // host port functions only in host mode
  assign wr_act = host_mode & mode_taken & sel & wr; // RQ11 RQ14
  assign rd_act = host_mode & mode_taken & sel & rd; // RQ11 RQ14
  assign lat_act = host_mode & mode_taken & sel & lat; // RQ11
  // either select or strobe high ends the access
  assign acc_end = ((state == ST_WRITE) & ~wr_act & ~ended) |
    ((state == ST_READ) & ~rd_act & ~ended); // RQ14
  assign sro = overlay_o[host_port_pkg::SRO_BIT]; // RQ8
  assign is_pm = addr[host_port_pkg::PM_SEL_BIT];
  assign is_ovl = (addr == host_port_pkg::OVERLAY_ADDR);
  // ---------------------------------------------------------------
  // read word mux
  // ---------------------------------------------------------------
  // program words come as upper sixteen then low eight bits
  always_comb
  begin
    if (is_pm)
    begin
      if (pm_half)
        read_word = {8'h00, pm[addr[PAW-1:0]][7:0]}; // RQ7
      else
        read_word = pm[addr[PAW-1:0]][23:8]; // RQ7
    end
    else if (is_ovl)
      read_word = overlay_o; // RQ9
    else
      read_word = dm[addr[DAW-1:0]]; // RQ7
  end
  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  // busy spans the sync delay plus the least low delay
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      busy <= 1'b0;
      cnt <= 3'h0;
      tgt <= 3'h0;
      ended <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          cnt <= 3'h0;
          ended <= 1'b0;
          if (wr_act)
          begin
            state <= ST_WRITE;
            busy <= 1'b1; // RQ3
            tgt <= 3'(host_port_pkg::ACK_LOW_CYC); // RQ2
          end
          else if (rd_act)
          begin
            state <= ST_READ;
            busy <= 1'b1; // RQ3
            // a fast read needs no fetch before release
            tgt <= sro ? 3'(host_port_pkg::ACK_SRO_CYC) :
              3'(host_port_pkg::ACK_LOW_CYC); // RQ5 RQ6
          end
        end
        ST_WRITE, ST_READ:
        begin
          if (cnt != tgt)
            cnt <= cnt + 3'h1;
          else
            busy <= 1'b0; // RQ2 RQ5
          if (acc_end)
            ended <= 1'b1;
          // leave only once both the end and the delay are over
          if ((ended | acc_end) & (cnt == tgt))
            state <= ST_IDLE;
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // address, write staging, program word halves
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      addr <= 16'h0000;
      pm_half <= 1'b0;
      pm_hi <= 16'h0000;
      wdata <= 16'h0000;
    end
    else
    begin
      // keep the last word seen while the strobe was low
      if (wr_act)
        wdata <= ad_s2;
      if (lat_act & (state == ST_IDLE))
      begin
        addr <= ad_s2;
        pm_half <= 1'b0;
      end
      else if (acc_end)
      begin
        if (is_pm & !pm_half)
        begin
          pm_half <= 1'b1; // RQ7
          if (state == ST_WRITE)
            pm_hi <= wdata;
        end
        else
        begin
          pm_half <= 1'b0; // RQ7
          addr <= addr + 16'h0001;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // memories, no reset
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (acc_end & (state == ST_WRITE))
    begin
      if (is_pm & pm_half)
        pm[addr[PAW-1:0]] <= {pm_hi, wdata[host_port_pkg::PM_LO_W-1:0]};
      else if (!is_pm & !is_ovl)
        dm[addr[DAW-1:0]] <= wdata;
    end
  end
  // ---------------------------------------------------------------
  // overlay register
  // ---------------------------------------------------------------
  // host write wins over a core write in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      overlay_o <= host_port_pkg::OVERLAY_RESET; // RQ8
    else if (acc_end & (state == ST_WRITE) & is_ovl)
      overlay_o <= wdata; // RQ9
    else if (core_ovl_we_i)
      overlay_o <= core_ovl_data_i; // RQ9
  end
  // ---------------------------------------------------------------
  // read data and bus drive
  // ---------------------------------------------------------------
  // idle refetch keeps the next word ready for a fast read
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_word <= 16'h0000;
      rd_oe <= 1'b0;
    end
    else
    begin
      if ((state == ST_IDLE) & !(rd_act & sro))
        out_word <= read_word; // RQ5
      if ((state == ST_IDLE) & rd_act)
        rd_oe <= 1'b1; // RQ5 RQ6
      else if (acc_end)
        rd_oe <= 1'b0; // RQ6
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // raw term meets the fast rise; it dies once the sequencer has it
  assign raw_acc = host_mode & mode_taken & ~port.select_n &
    (~port.read_strobe_n | ~port.write_strobe_n);
  assign port.ack = busy | (raw_acc & (state == ST_IDLE)); // RQ3
  assign port.ad_dev = out_word;
  assign port.ad_dev_oe = rd_oe & host_mode; // RQ11
  assign host_mode_o = host_mode;
endmodule

// ---- verilog/host_port_pkg.sv ----
// Notes on behaviour
// RQ1 - host writes only after acknowledge is low
// RQ2 - long write: acknowledge low after 1.5 periods
// RQ3 - acknowledge rises within 10 ns of access
// RQ4 - host reads only after acknowledge is low
// RQ5 - long read: word on bus before acknowledge low
// RQ6 - fast reads drive previous word until end
// RQ7 - data word one read, program word two
// RQ8 - overlay bit 14 enables fast reads, reset clear
// RQ9 - overlay writable by core and by host
// RQ10 - host should prefer fast reads over short reads
// RQ11 - mode pin high selects host port pins
// RQ12 - mode pin captured at reset release
// RQ13 - host latches address before each access run
// RQ14 - access: select and strobe low; ends either high
package host_port_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8; // processor clock period
  localparam int ACK_LOW_MIN_HALF_TCK = 3; // 1.5 periods, in halves
  localparam int ACK_LOW_CYC = (ACK_LOW_MIN_HALF_TCK + 1) / 2; // round up
  localparam int ACK_SRO_CYC = 1; // busy time of a fast read
  localparam int ACK_HIGH_MAX_NS = 10; // access start to busy
  localparam int ACK_HIGH_CYC = (ACK_HIGH_MAX_NS / CLK_PERIOD_NS < 1) ?
    1 : ACK_HIGH_MAX_NS / CLK_PERIOD_NS; // round down, least one
  localparam int LATCH_MIN_NS = 10; // least address latch pulse
  localparam int LATCH_CYC = (LATCH_MIN_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS; // round up
  localparam int SYNC_CYC = 2; // two flop synchroniser latency
  localparam int STROBE_CYC = ACK_HIGH_CYC + SYNC_CYC; // see busy
  localparam int HOST_GAP_CYC = 4; // idle between accesses
  // ---------------------------------------------------------------
  // device memory map
  // ---------------------------------------------------------------
  localparam logic [15:0] OVERLAY_ADDR = 16'h3fe7; // overlay word
  localparam logic [15:0] OVERLAY_RESET = 16'h0000; // all clear
  localparam int SRO_BIT = 14; // fast read enable bit
  localparam int PM_SEL_BIT = 15; // address bit picking program mem
  localparam int PM_LO_W = 8; // low bits of a program word
  localparam int AD_W = 16; // width of the shared bus
  // ---------------------------------------------------------------
  // synchroniser lanes for control pins
  // ---------------------------------------------------------------
  localparam int CTL_SEL = 0;
  localparam int CTL_LAT = 1;
  localparam int CTL_RD = 2;
  localparam int CTL_WR = 3;
  localparam int CTL_MODE = 4;
  localparam int CTL_W = 5;
  // ---------------------------------------------------------------
  // controller registers on the system bus
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // op start
  localparam logic [7:0] REG_ADDR = 8'h04; // address to latch
  localparam logic [7:0] REG_WDATA = 8'h08; // word to write
  localparam logic [7:0] REG_RDATA = 8'h0c; // last word read
  localparam logic [7:0] REG_STATUS = 8'h10; // busy, ack, mode
  localparam logic [1:0] OP_LATCH = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
endpackage

// ---- verilog/host_port_if.sv ----
`timescale 1ns/10ps
interface host_port_if;
  logic select_n; // access select, low active
  logic address_latch; // address latch strobe, high active
  logic read_strobe_n; // read strobe, low active
  logic write_strobe_n; // write strobe, low active
  logic mode_c; // host mode strap
  logic [15:0] ad_host; // host drive value
  logic ad_host_oe; // host drives bus
  logic [15:0] ad_dev; // device drive value
  logic ad_dev_oe; // device drives bus
  logic ack; // acknowledge, high while busy
  logic [15:0] ad_bus; // resolved shared bus
  // bus level from the two enables; a released bus rests at the
  // pull-up level, so a late sample shows all ones, not a stale word
  assign ad_bus = ad_dev_oe ? ad_dev : (ad_host_oe ? ad_host : 16'hffff);
  modport device (
    input select_n, address_latch, read_strobe_n, write_strobe_n,
    input mode_c, ad_bus,
    output ad_dev, ad_dev_oe, ack
  );
  modport host (
    output select_n, address_latch, read_strobe_n, write_strobe_n,
    output mode_c, ad_host, ad_host_oe,
    input ad_bus, ack
  );
endinterface

// ---- verilog/host_port_host.sv ----
`timescale 1ns/10ps
module host_port_host (
  input wire logic ref_clk_i, // controller clock
  input wire logic rst_i, // async reset, high
  host_port_if.host port, // host memory port pins
  input wire logic strap_mode_i, // level for the mode strap
  input wire logic hsel_i, // ahb select
  input wire logic [31:0] haddr_i, // ahb address
  input wire logic [1:0] htrans_i, // ahb transfer type
  input wire logic hwrite_i, // ahb write
  input wire logic [2:0] hsize_i, // ahb size, word only
  input wire logic [31:0] hwdata_i, // ahb write data
  input wire logic hready_i, // ahb ready in
  output logic [31:0] hrdata_o, // ahb read data
  output logic hreadyout_o, // ahb ready out
  output logic hresp_o // ahb response, okay
);
  typedef enum logic [2:0] {H_IDLE, H_WAIT_ACK, H_LATCH, H_STROBE,
    H_WAIT_LOW, H_END} hstate_t;
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic ap_valid, ap_write; // data phase pending
  logic [7:0] ap_addr; // registered offset
  logic [15:0] reg_addr, reg_wdata, reg_rdata; // controller regs
  logic [1:0] op; // current operation
  logic start; // ctrl write starts an op
  hstate_t hst; // pin sequencer
  logic [2:0] cnt; // phase counter
  logic ack_s1, ack_s2; // acknowledge sync
  logic [15:0] ad_s1, ad_s2; // bus sync
  logic [31:0] rd_val; // read mux
  // ---------------------------------------------------------------
  // ahb slave
  // ---------------------------------------------------------------
  assign hreadyout_o = 1'b1; // never waits
  assign hresp_o = 1'b0;
  assign start = ap_valid & ap_write & (ap_addr == host_port_pkg::REG_CTRL)
    & (hst == H_IDLE) & (hwdata_i[1:0] != 2'h0);
  // capture address phase
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
    end
    else if (hready_i)
    begin
      ap_valid <= hsel_i & htrans_i[1];
      ap_write <= hwrite_i;
      ap_addr <= haddr_i[7:0];
    end
  end
  // register writes in data phase
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_addr <= 16'h0000;
      reg_wdata <= 16'h0000;
    end
    else if (ap_valid & ap_write)
    begin
      if (ap_addr == host_port_pkg::REG_ADDR)
        reg_addr <= hwdata_i[15:0];
      if (ap_addr == host_port_pkg::REG_WDATA)
        reg_wdata <= hwdata_i[15:0];
    end
  end
  // read mux, unmapped reads give zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (haddr_i[7:0])
      host_port_pkg::REG_ADDR: rd_val = {16'h0000, reg_addr};
      host_port_pkg::REG_WDATA: rd_val = {16'h0000, reg_wdata};
      host_port_pkg::REG_RDATA: rd_val = {16'h0000, reg_rdata};
      host_port_pkg::REG_STATUS:
        rd_val = {29'h0000_0000, strap_mode_i, ack_s2, hst != H_IDLE};
      default: rd_val = 32'h0000_0000;
    endcase
  end
  // read data taken at address phase, forwarded from a pending write
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      hrdata_o <= 32'h0000_0000;
    else if (hready_i & hsel_i & htrans_i[1] & !hwrite_i)
    begin
      if (ap_valid & ap_write & (ap_addr == haddr_i[7:0]) &
        ((ap_addr == host_port_pkg::REG_ADDR) |
        (ap_addr == host_port_pkg::REG_WDATA)))
        hrdata_o <= {16'h0000, hwdata_i[15:0]};
      else
        hrdata_o <= rd_val;
    end
  end
  // ---------------------------------------------------------------
  // synchronisers on pins from the device
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    ack_s1 <= port.ack;
    ack_s2 <= ack_s1;
    ad_s1 <= port.ad_bus;
    ad_s2 <= ad_s1;
  end
  // ---------------------------------------------------------------
  // pin sequencer
  // ---------------------------------------------------------------
  assign port.mode_c = strap_mode_i;
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hst <= H_IDLE;
      cnt <= 3'h0;
      op <= 2'h0;
      reg_rdata <= 16'h0000;
      port.select_n <= 1'b1;
      port.address_latch <= 1'b0;
      port.read_strobe_n <= 1'b1;
      port.write_strobe_n <= 1'b1;
      port.ad_host <= 16'h0000;
      port.ad_host_oe <= 1'b0;
    end
    else
    begin
      unique case (hst)
        H_IDLE:
        begin
          cnt <= 3'h0;
          if (start)
          begin
            op <= hwdata_i[1:0];
            hst <= H_WAIT_ACK;
          end
        end
        // nothing starts before the device is idle
        H_WAIT_ACK:
          if (!ack_s2) // RQ1 RQ4
          begin
            port.select_n <= 1'b0;
            if (op == host_port_pkg::OP_LATCH)
            begin
              port.address_latch <= 1'b1; // RQ13
              port.ad_host <= reg_addr;
              port.ad_host_oe <= 1'b1;
              hst <= H_LATCH;
            end
            else if (op == host_port_pkg::OP_WRITE)
            begin
              port.write_strobe_n <= 1'b0; // RQ1
              port.ad_host <= reg_wdata;
              port.ad_host_oe <= 1'b1;
              hst <= H_STROBE;
            end
            else
            begin
              port.read_strobe_n <= 1'b0; // RQ4 RQ10
              hst <= H_STROBE;
            end
          end
        H_LATCH:
        begin
          cnt <= cnt + 3'h1;
          if (cnt == 3'(host_port_pkg::LATCH_CYC - 1))
          begin
            port.address_latch <= 1'b0; // RQ13
            port.select_n <= 1'b1;
            cnt <= 3'h0;
            hst <= H_END;
          end
        end
        // wait until busy is surely visible through the sync
        H_STROBE:
        begin
          cnt <= cnt + 3'h1;
          if (cnt == 3'(host_port_pkg::STROBE_CYC - 1))
            hst <= H_WAIT_LOW;
        end
        H_WAIT_LOW:
          if (!ack_s2)
          begin
            if (op == host_port_pkg::OP_READ)
              reg_rdata <= ad_s2; // RQ5
            port.select_n <= 1'b1; // RQ14
            port.read_strobe_n <= 1'b1;
            port.write_strobe_n <= 1'b1;
            cnt <= 3'h0;
            hst <= H_END;
          end
        // bus held one more cycle, then a gap for the device
        H_END:
        begin
          port.ad_host_oe <= 1'b0;
          cnt <= cnt + 3'h1;
          if (cnt == 3'(host_port_pkg::HOST_GAP_CYC - 1))
            hst <= H_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- dv/host_port_monitor.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// link checker
// ------------------------------------------------------------
module host_port_monitor (
  input wire logic ref_clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic select_n, // select
  input wire logic read_strobe_n, // read strobe
  input wire logic write_strobe_n, // write strobe
  input wire logic mode_c, // strap
  input wire logic [15:0] ad_dev, // device word
  input wire logic ad_dev_oe, // device drives
  input wire logic ack // high while busy
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // access decode, as the device sees the raw pins
  wire wr_on = mode_c && !select_n && !write_strobe_n;
  wire rd_on = mode_c && !select_n && !read_strobe_n;
  // busy must cover 1.5 periods, so three samples
  sequence busy3;
    ack [*3];
  endsequence
  // a stuck busy would hang the host, so bound it
  sequence done_soon;
    ##[1:40] !ack;
  endsequence
  ack_rise_a: assert property ($rose(wr_on) || $rose(rd_on) |-> ack)
    else $error("busy late");
  long_write_a: assert property ($rose(wr_on) |-> busy3)
    else $error("ready too early");
  ack_done_a: assert property ($rose(wr_on) || $rose(rd_on) |-> done_soon)
    else $error("busy stuck");
  read_data_a: assert property ($fell(ack) && rd_on |->
    ad_dev_oe && $past(ad_dev_oe) && $stable(ad_dev)) else $error("word late");
  read_hold_a: assert property (rd_on && ad_dev_oe && !ack |=>
    (ad_dev_oe && $stable(ad_dev)) || !rd_on) else $error("word dropped");
  wr_quiet_a: assert property (wr_on |-> !ad_dev_oe)
    else $error("bus fight");
  bus_free_a: assert property ($fell(rd_on) |-> ##[0:4] !ad_dev_oe)
    else $error("bus held");
  idle_quiet_a: assert property (select_n && $past(select_n, 8) |-> !ack)
    else $error("busy when idle");
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic ref_clk_i = 0; // 125 MHz
  logic rst_i = 1; // reset
  logic strap = 1; // mode strap level
  logic hsel, hwrite, hready, hresp, core_we, host_mode; // bus, core
  logic [1:0] htrans; // transfer kind
  logic [31:0] haddr, hwdata, hrdata, q; // bus words
  logic [15:0] core_data, overlay, base; // core side
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  initial forever #4 ref_clk_i = ~ref_clk_i;
  host_port_if u_host_port_if ();
  host_port_device u_host_port_device (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .port(u_host_port_if), .core_ovl_we_i(core_we),
    .core_ovl_data_i(core_data), .overlay_o(overlay),
    .host_mode_o(host_mode));
  // strap from the bench: host mode first, then a low strap
  host_port_host u_host_port_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .port(u_host_port_if), .strap_mode_i(strap), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp));
  host_port_monitor u_host_port_monitor (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .select_n(u_host_port_if.select_n),
    .read_strobe_n(u_host_port_if.read_strobe_n),
    .write_strobe_n(u_host_port_if.write_strobe_n),
    .mode_c(u_host_port_if.mode_c), .ad_dev(u_host_port_if.ad_dev),
    .ad_dev_oe(u_host_port_if.ad_dev_oe), .ack(u_host_port_if.ack));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // one single transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge ref_clk_i);
    while (hready !== 1'b1) @(posedge ref_clk_i);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge ref_clk_i);
    while (hready !== 1'b1) @(posedge ref_clk_i);
    r = hrdata;
  endtask
  // pin operation: load operand, start, poll busy, fetch word
  task automatic op(input logic [1:0] c, input logic [15:0] d);
    logic [31:0] s;
    int n;
    n = 0;
    ahb(1, (c == host_port_pkg::OP_LATCH) ? host_port_pkg::REG_ADDR :
      host_port_pkg::REG_WDATA, {16'h0000, d}, s);
    ahb(1, host_port_pkg::REG_CTRL, {30'h0000_0000, c}, s);
    // status lags the start by a register stage
    repeat (2) @(posedge ref_clk_i);
    do
    begin
      ahb(0, host_port_pkg::REG_STATUS, 32'h0000_0000, s);
      n++;
    end
    while (s[0] !== 1'b0 && n < 300);
    chk({31'h0000_0000, s[0]}, 32'h0000_0000);
    ahb(0, host_port_pkg::REG_RDATA, 32'h0000_0000, q);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // hang guard
  // ------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      close_out;
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    {hsel, hwrite, core_we, htrans, haddr, hwdata, core_data} = '0;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 0;
    repeat (4) @(posedge ref_clk_i);
    chk({16'h0000, overlay}, 32'h0000_0000);
    chk({31'h0000_0000, host_mode}, 32'h0000_0001);
    $display("reset test done");
    // two data words, then program word in two halves
    for (int i = 0; i < 2; i++)
    begin
      base = i ? 16'h8005 : 16'h0010;
      op(host_port_pkg::OP_LATCH, base);
      op(host_port_pkg::OP_WRITE, 16'h1234);
      op(host_port_pkg::OP_WRITE, 16'h00a8);
      op(host_port_pkg::OP_LATCH, base);
      op(host_port_pkg::OP_READ, 16'h0000);
      chk(q, 32'h0000_1234);
      op(host_port_pkg::OP_READ, 16'h0000);
      chk(q, 32'h0000_00a8);
    end
    $display("memory test done");
    // host turns on fast reads through the port
    op(host_port_pkg::OP_LATCH, 16'h3fe7);
    op(host_port_pkg::OP_WRITE, 16'h4000);
    chk({16'h0000, overlay}, 32'h0000_4000);
    op(host_port_pkg::OP_LATCH, 16'h0010);
    op(host_port_pkg::OP_READ, 16'h0000);
    chk(q, 32'h0000_1234);
    op(host_port_pkg::OP_READ, 16'h0000);
    chk(q, 32'h0000_00a8);
    $display("fast read test done");
    // core turns them off again, long reads resume
    core_we <= 1;
    @(posedge ref_clk_i);
    core_we <= 0;
    @(posedge ref_clk_i);
    chk({16'h0000, overlay}, 32'h0000_0000);
    op(host_port_pkg::OP_LATCH, 16'h8005);
    op(host_port_pkg::OP_READ, 16'h0000);
    chk(q, 32'h0000_1234);
    ahb(0, 8'h20, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    $display("overlay test done");
    // second reset with the strap low: the port must ignore the pins
    rst_i <= 1;
    strap <= 0;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 0;
    repeat (4) @(posedge ref_clk_i);
    chk({31'h0000_0000, host_mode}, 32'h0000_0000);
    op(host_port_pkg::OP_LATCH, 16'h3fe7);
    op(host_port_pkg::OP_WRITE, 16'h4000);
    chk({16'h0000, overlay}, 32'h0000_0000);
    ahb(0, host_port_pkg::REG_STATUS, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    // strap rises after release; the captured mode must not follow
    strap <= 1;
    repeat (8) @(posedge ref_clk_i);
    chk({31'h0000_0000, host_mode}, 32'h0000_0000);
    $display("strap test done");
    close_out;
  end
endmodule
